// >>> src/refmon_pkg.sv
// constants, register map and types for the reference monitor and switchover block
package refmon_pkg;
    // byte offsets are the printed offsets times four
    localparam logic [11:0] AUTO_MODE_IDX  = 12'h1C0;
    localparam logic [11:0] OVERRIDE_IDX   = 12'h1C1;
    localparam logic [13:0] ADDR_AUTO_MODE = {AUTO_MODE_IDX, 2'b00};
    localparam logic [13:0] ADDR_OVERRIDE  = {OVERRIDE_IDX, 2'b00};
    localparam logic [13:0] ADDR_MON_CTRL  = 14'h0800;
    localparam logic [13:0] ADDR_STATUS    = 14'h0804;
    localparam logic [13:0] ADDR_IRQ_STAT  = 14'h0808;
    localparam logic [13:0] ADDR_IRQ_MASK  = 14'h080C;
    localparam logic [13:0] ADDR_PIN_ROUTE = 14'h0810;
    localparam logic [13:0] ADDR_DIV_A     = 14'h0820;
    localparam logic [13:0] ADDR_LOW_A     = 14'h0824;
    localparam logic [13:0] ADDR_HIGH_A    = 14'h0828;
    localparam logic [13:0] ADDR_DIV_B     = 14'h0830;
    localparam logic [13:0] ADDR_LOW_B     = 14'h0834;
    localparam logic [13:0] ADDR_HIGH_B    = 14'h0838;
    localparam logic [13:0] ADDR_SM_CTRL   = 14'h0840;

    // auto mode control fields
    localparam int AUTO_HOLD_BIT   = 0;
    localparam int AUTO_REF_BIT    = 2;
    localparam int HOLD_MODE_BIT   = 4;
    // override control fields
    localparam int HOLD_FORCE_BIT  = 0;
    localparam int HOLD_OVR_BIT    = 1;
    localparam int FORCED_REF_BIT  = 2;
    localparam int REF_OVR_BIT     = 3;
    localparam int EDGE_ALIGN_BIT  = 4;

    localparam int NUM_REF         = 2;
    localparam int CNT_W           = 32;
    localparam int DIV_W           = 16;
    localparam int NUM_SPIN        = 4;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] DIV_RESET   = 16'h0001;
    localparam logic [31:0] LOW_RESET   = 32'h00000000;
    localparam logic [31:0] HIGH_RESET  = 32'hFFFFFFFF;
    localparam logic [31:0] BUS_UNMAPPED = 32'h00000000;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [CNT_W-1:0] low;
        logic [CNT_W-1:0] high;
    } mon_cfg_t;

    typedef struct packed {
        logic [2:0] src;
        logic       en;
    } pin_route_t;

    typedef enum logic [1:0] {
        SM_A_NORMAL,
        SM_B_NORMAL,
        SM_A_HOLD,
        SM_B_HOLD
    } sm_state_t;
endpackage : refmon_pkg

// >>> src/ref_monitor_switchover.sv
// two-reference frequency monitor with reference and holdover selection
module ref_monitor_switchover
    import refmon_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic [31:0] WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output logic             WB_ACK_O,
    input  wire logic [1:0]  REF_IN,
    input  wire logic        REF_CHOICE_PIN_I,
    output logic             REF_CHOICE_PIN_O,
    output logic             REF_CHOICE_PIN_OE,
    input  wire logic        HOLDOVER_PIN_I,
    output logic             HOLDOVER_PIN_O,
    output logic             HOLDOVER_PIN_OE,
    output logic [3:0]       MULTIPURPOSE_STATUS_PINS,
    output logic             ACTIVE_REF,
    output logic             HOLDOVER_ACTIVE,
    output logic             IRQ
);

    // byte-lane merge for 32-bit registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // zero would wrap the divider compare to a window of every 65536th rise
    function automatic logic [DIV_W-1:0] div_merge(input logic [DIV_W-1:0] old_v, input logic [31:0] new_v,
                                                   input logic [3:0] sel);
        logic [DIV_W-1:0] r;
        r = DIV_W'(lane_merge({16'h0000, old_v}, new_v, sel));
        return (r == '0) ? DIV_RESET : r;
    endfunction : div_merge

    // software-visible state
    logic [7:0]              auto_mode_reg;
    logic [7:0]              override_reg;
    logic [NUM_REF-1:0]      mon_en_reg;
    logic [NUM_REF-1:0]      ool_status_reg;
    logic [NUM_REF-1:0]      irq_stat_reg;
    logic [NUM_REF-1:0]      irq_mask_reg;
    logic [NUM_REF-1:0]      sm_force_reg;
    pin_route_t [NUM_SPIN-1:0] route_reg;
    mon_cfg_t [NUM_REF-1:0]  cfg_reg;
    logic                    ack_reg;
    logic [31:0]             rdata_reg;
    logic [NUM_REF-1:0]      ool_event;
    logic [NUM_REF-1:0]      in_limit_event;

    // ack_reg masks the hold cycle
    logic        bus_req;
    logic        bus_wr;
    logic [13:0] addr;
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
    assign bus_wr  = bus_req && WB_WE_I;
    assign addr    = WB_ADR_I[13:0];
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;

    // one wait-free answer: ack the cycle after the request, drop it the next
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // writes land on the taking edge
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            auto_mode_reg <= CTRL_RESET;
            override_reg  <= CTRL_RESET;
            mon_en_reg    <= '0;
            irq_mask_reg  <= '0;
            sm_force_reg  <= '0;
            route_reg     <= '0;
            for (int r = 0; r < NUM_REF; r++) begin
                cfg_reg[r].div  <= DIV_RESET;
                cfg_reg[r].low  <= LOW_RESET;
                cfg_reg[r].high <= HIGH_RESET;
            end
        end else if (bus_wr) begin
            unique case (addr)
                ADDR_AUTO_MODE: if (WB_SEL_I[0]) auto_mode_reg <= WB_DAT_I[7:0];
                ADDR_OVERRIDE:  if (WB_SEL_I[0]) override_reg <= WB_DAT_I[7:0];
                ADDR_MON_CTRL:  if (WB_SEL_I[0]) mon_en_reg <= WB_DAT_I[NUM_REF-1:0];
                ADDR_IRQ_MASK:  if (WB_SEL_I[0]) irq_mask_reg <= WB_DAT_I[NUM_REF-1:0];
                ADDR_SM_CTRL:   if (WB_SEL_I[0]) sm_force_reg <= WB_DAT_I[NUM_REF-1:0];
                ADDR_PIN_ROUTE: begin
                    for (int p = 0; p < NUM_SPIN; p++) begin
                        if (WB_SEL_I[p]) route_reg[p] <= pin_route_t'(WB_DAT_I[8*p +: 4]);
                    end
                end
                ADDR_DIV_A: begin
                    cfg_reg[0].div <= div_merge(cfg_reg[0].div, WB_DAT_I, WB_SEL_I);
                end
                ADDR_DIV_B: begin
                    cfg_reg[1].div <= div_merge(cfg_reg[1].div, WB_DAT_I, WB_SEL_I);
                end
                ADDR_LOW_A:  cfg_reg[0].low  <= lane_merge(cfg_reg[0].low,  WB_DAT_I, WB_SEL_I);
                ADDR_HIGH_A: cfg_reg[0].high <= lane_merge(cfg_reg[0].high, WB_DAT_I, WB_SEL_I);
                ADDR_LOW_B:  cfg_reg[1].low  <= lane_merge(cfg_reg[1].low,  WB_DAT_I, WB_SEL_I);
                ADDR_HIGH_B: cfg_reg[1].high <= lane_merge(cfg_reg[1].high, WB_DAT_I, WB_SEL_I);
                default: ;
            endcase
        end
    end

    // read mux, registered so data lines up with ack
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= BUS_UNMAPPED;
        end else if (bus_req && !WB_WE_I) begin
            unique case (addr)
                ADDR_AUTO_MODE: rdata_reg <= {24'h000000, auto_mode_reg};
                ADDR_OVERRIDE:  rdata_reg <= {24'h000000, override_reg};
                ADDR_MON_CTRL:  rdata_reg <= {30'h00000000, mon_en_reg};
                ADDR_STATUS:    rdata_reg <= {26'h0000000, HOLDOVER_ACTIVE, ACTIVE_REF, 2'b00, ool_status_reg};
                ADDR_IRQ_STAT:  rdata_reg <= {30'h00000000, irq_stat_reg};
                ADDR_IRQ_MASK:  rdata_reg <= {30'h00000000, irq_mask_reg};
                ADDR_SM_CTRL:   rdata_reg <= {30'h00000000, sm_force_reg};
                ADDR_PIN_ROUTE: rdata_reg <= {4'h0, route_reg[3], 4'h0, route_reg[2],
                                              4'h0, route_reg[1], 4'h0, route_reg[0]};
                ADDR_DIV_A:     rdata_reg <= {16'h0000, cfg_reg[0].div};
                ADDR_LOW_A:     rdata_reg <= cfg_reg[0].low;
                ADDR_HIGH_A:    rdata_reg <= cfg_reg[0].high;
                ADDR_DIV_B:     rdata_reg <= {16'h0000, cfg_reg[1].div};
                ADDR_LOW_B:     rdata_reg <= cfg_reg[1].low;
                ADDR_HIGH_B:    rdata_reg <= cfg_reg[1].high;
                default:        rdata_reg <= BUS_UNMAPPED;
            endcase
        end
    end

    // frequency monitors: references sampled on CLK, edges divided, then
    // the CLK count between adjacent divided edges is compared with the limits
    genvar g;
    generate
        for (g = 0; g < NUM_REF; g++) begin : g_mon
            logic             ref_d1_reg;
            logic             ref_d2_reg;
            logic [DIV_W-1:0] div_cnt_reg;
            logic [CNT_W-1:0] period_cnt_reg;
            logic             primed_reg;
            logic             ref_rise;
            logic             div_edge;

            assign ref_rise = ref_d1_reg && !ref_d2_reg;
            assign div_edge = ref_rise && (div_cnt_reg >= cfg_reg[g].div - DIV_W'(1));

            // pair of samples gives a rise strobe
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    ref_d1_reg <= 1'b0;
                    ref_d2_reg <= 1'b0;
                end else begin
                    ref_d1_reg <= REF_IN[g];
                    ref_d2_reg <= ref_d1_reg;
                end
            end

            // every D-th rise closes a window
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    div_cnt_reg <= '0;
                end else if (!mon_en_reg[g] || div_edge) begin
                    div_cnt_reg <= '0;
                end else if (ref_rise) begin
                    div_cnt_reg <= div_cnt_reg + DIV_W'(1);
                end
            end

            // counting on CLK ties accuracy to the system clock
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    period_cnt_reg <= '0;
                    primed_reg     <= 1'b0;
                end else if (!mon_en_reg[g]) begin
                    period_cnt_reg <= '0;
                    primed_reg     <= 1'b0;
                end else if (div_edge) begin
                    period_cnt_reg <= CNT_W'(1);
                    primed_reg     <= 1'b1;
                end else if (period_cnt_reg != HIGH_RESET) begin
                    period_cnt_reg <= period_cnt_reg + CNT_W'(1);
                end
            end

            // the first edge only starts a window, so it is never judged
            assign ool_event[g] = div_edge && primed_reg &&
                                  (period_cnt_reg < cfg_reg[g].low || period_cnt_reg > cfg_reg[g].high);
            assign in_limit_event[g] = div_edge && primed_reg && !ool_event[g];

            // disable clears a stale flag
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    ool_status_reg[g] <= 1'b0;
                end else if (!mon_en_reg[g]) begin
                    ool_status_reg[g] <= 1'b0;
                end else if (ool_event[g]) begin
                    ool_status_reg[g] <= 1'b1;
                end else if (in_limit_event[g]) begin
                    ool_status_reg[g] <= 1'b0;
                end
            end

            // a new event beats a same-cycle write-one-to-clear
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    irq_stat_reg[g] <= 1'b0;
                end else if (ool_event[g]) begin
                    irq_stat_reg[g] <= 1'b1;
                end else if (bus_wr && addr == ADDR_IRQ_STAT && WB_SEL_I[0] && WB_DAT_I[g]) begin
                    irq_stat_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // level output, no edge to miss
    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    // one cycle behind the flags
    generate
        for (g = 0; g < NUM_SPIN; g++) begin : g_spin
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    MULTIPURPOSE_STATUS_PINS[g] <= 1'b0;
                end else begin
                    MULTIPURPOSE_STATUS_PINS[g] <= route_reg[g].en &&
                                                   ool_status_reg[route_reg[g].src[0]];
                end
            end
        end
    endgenerate

    // internal state machine: fall back to the other reference on failure,
    // holdover when both fail; validation timers are not modelled, so a
    // recovered reference is eligible as soon as its flag clears
    sm_state_t   sm_reg;
    sm_state_t   sm_next;
    logic [1:0]  ref_bad;
    assign ref_bad = ool_status_reg | sm_force_reg;

    always_comb begin
        sm_next = sm_reg;
        unique case (sm_reg)
            SM_A_NORMAL: if (ref_bad[0]) sm_next = ref_bad[1] ? SM_A_HOLD : SM_B_NORMAL;
            SM_B_NORMAL: if (ref_bad[1]) sm_next = ref_bad[0] ? SM_B_HOLD : SM_A_NORMAL;
            SM_A_HOLD:   if (!ref_bad[0]) sm_next = SM_A_NORMAL;
                         else if (!ref_bad[1]) sm_next = SM_B_NORMAL;
            SM_B_HOLD:   if (!ref_bad[1]) sm_next = SM_B_NORMAL;
                         else if (!ref_bad[0]) sm_next = SM_A_NORMAL;
        endcase
    end

    // starts on reference A, not in holdover
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sm_reg <= SM_A_NORMAL;
        end else begin
            sm_reg <= sm_next;
        end
    end

    // decoded machine outputs
    logic sm_ref;
    logic sm_hold;
    assign sm_ref  = (sm_reg == SM_B_NORMAL) || (sm_reg == SM_B_HOLD);
    assign sm_hold = (sm_reg == SM_A_HOLD) || (sm_reg == SM_B_HOLD);

    // pins: outputs report the machine, never the forced value
    assign REF_CHOICE_PIN_OE = auto_mode_reg[AUTO_REF_BIT];
    assign REF_CHOICE_PIN_O  = sm_ref;
    assign HOLDOVER_PIN_OE   = auto_mode_reg[AUTO_HOLD_BIT];
    assign HOLDOVER_PIN_O    = sm_hold;

    // override only acts in auto mode
    logic ref_cmd;
    logic hold_cmd;
    always_comb begin
        if (!auto_mode_reg[AUTO_REF_BIT]) begin
            ref_cmd = REF_CHOICE_PIN_I;
        end else if (override_reg[REF_OVR_BIT]) begin
            ref_cmd = override_reg[FORCED_REF_BIT];
        end else begin
            ref_cmd = sm_ref;
        end
        if (!auto_mode_reg[AUTO_HOLD_BIT]) begin
            hold_cmd = HOLDOVER_PIN_I;
        end else if (override_reg[HOLD_OVR_BIT]) begin
            hold_cmd = override_reg[HOLD_FORCE_BIT] | auto_mode_reg[HOLD_MODE_BIT];
        end else begin
            hold_cmd = sm_hold;
        end
    end

    // in holdover the active reference is frozen
    logic ref_want;
    assign ref_want = hold_cmd ? ACTIVE_REF : ref_cmd;

    // idle low after reset: no false edge
    logic [1:0] alt_d_reg;
    logic       alt_rise;
    assign alt_rise = ACTIVE_REF ? (REF_IN[0] && !alt_d_reg[0]) : (REF_IN[1] && !alt_d_reg[1]);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            alt_d_reg <= 2'b00;
        end else begin
            alt_d_reg <= REF_IN;
        end
    end

    // edge-aligned switch waits for a rising edge of the target reference,
    // seen on CLK; this avoids a second clock domain at one cycle of latency
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ACTIVE_REF <= 1'b0;
        end else if (ref_want != ACTIVE_REF) begin
            if (!override_reg[EDGE_ALIGN_BIT]) begin
                ACTIVE_REF <= ref_want;
            end else if (alt_rise) begin
                ACTIVE_REF <= ref_want;
            end
        end
    end

    // registered like the active reference
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            HOLDOVER_ACTIVE <= 1'b0;
        end else begin
            HOLDOVER_ACTIVE <= hold_cmd;
        end
    end

endmodule : ref_monitor_switchover

// >>> verification/ref_switch_monitor.sv
// concurrent checks on the ports of the reference monitor and switchover block
module ref_switch_monitor (
    input wire logic       CLK,
    input wire logic       RST_B,
    input wire logic       WB_WE_I,
    input wire logic       WB_CYC_I,
    input wire logic       WB_STB_I,
    input wire logic       WB_ACK_O,
    input wire logic       REF_CHOICE_PIN_OE,
    input wire logic       HOLDOVER_PIN_OE,
    input wire logic [3:0] MULTIPURPOSE_STATUS_PINS,
    input wire logic       ACTIVE_REF,
    input wire logic       HOLDOVER_ACTIVE,
    input wire logic       IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    wire logic wr = WB_CYC_I && WB_STB_I && WB_WE_I;

    a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after a request");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without a request");
    a_reset_quiet: assert property ($rose(RST_B) |-> MULTIPURPOSE_STATUS_PINS == 4'h0 && !IRQ
        && !ACTIVE_REF && !REF_CHOICE_PIN_OE && !HOLDOVER_PIN_OE && !WB_ACK_O)
        else $error("outputs not quiet after reset");
    a_ref_oe_write: assert property ($changed(REF_CHOICE_PIN_OE) |-> $past(wr))
        else $error("choice pin direction changed without a write");
    a_hold_oe_write: assert property ($changed(HOLDOVER_PIN_OE) |-> $past(wr))
        else $error("holdover pin direction changed without a write");
    a_irq_clear_write: assert property ($fell(IRQ) |-> $past(wr))
        else $error("interrupt dropped without a write");
    // three cycles of holdover leave room for a switch already under way
    a_hold_freeze: assert property (HOLDOVER_ACTIVE && $past(HOLDOVER_ACTIVE)
        && $past(HOLDOVER_ACTIVE, 2) |-> $stable(ACTIVE_REF))
        else $error("active reference moved during holdover");
endmodule : ref_switch_monitor

bind ref_monitor_switchover ref_switch_monitor u_mon (.CLK(CLK), .RST_B(RST_B), .WB_WE_I(WB_WE_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .REF_CHOICE_PIN_OE(REF_CHOICE_PIN_OE),
    .HOLDOVER_PIN_OE(HOLDOVER_PIN_OE), .MULTIPURPOSE_STATUS_PINS(MULTIPURPOSE_STATUS_PINS),
    .ACTIVE_REF(ACTIVE_REF), .HOLDOVER_ACTIVE(HOLDOVER_ACTIVE), .IRQ(IRQ));

// >>> verification/ref_source_model.sv
// two reference clock sources and the far side of the choice and holdover pins
module ref_source_model (
    input  wire logic       clk,
    input  wire logic [1:0] run,
    input  wire logic [7:0] half_a,
    input  wire logic [7:0] half_b,
    input  wire logic       choice_drv,
    input  wire logic       hold_drv,
    input  wire logic       choice_o,
    input  wire logic       choice_oe,
    input  wire logic       hold_o,
    input  wire logic       hold_oe,
    output logic      [1:0] ref_out,
    output logic            choice_pin,
    output logic            hold_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_reg [2];

    initial begin
        ref_out = 2'b00;
        cnt_reg = '{8'h00, 8'h00};
    end
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!run[i]) begin
                // a stopped source stands low, so no edge can sneak in
                cnt_reg[i] <= 8'h00;
                ref_out[i] <= 1'b0;
            end else if (cnt_reg[i] >= (i ? half_b : half_a) - 8'h01) begin
                cnt_reg[i] <= 8'h00;
                ref_out[i] <= ~ref_out[i];
            end else begin
                cnt_reg[i] <= cnt_reg[i] + 8'h01;
            end
        end
    end
    assign choice_pin = choice_oe ? choice_o : choice_drv;
    assign hold_pin   = hold_oe ? hold_o : hold_drv;
endmodule : ref_source_model

// >>> verification/ref_monitor_switchover_test.sv
// self-checking bench for the reference monitor and switchover block
module ref_monitor_switchover_test import refmon_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        CLK = 1'b0, RST_B = 1'b0, WB_WE_I = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
    logic [31:0] WB_ADR_I = 32'h0, WB_DAT_I = 32'h0, WB_DAT_O, q;
    logic [3:0]  WB_SEL_I = 4'hF, MULTIPURPOSE_STATUS_PINS;
    logic [1:0]  REF_IN, run = 2'b11;
    logic [7:0]  half_a = 8'h04, half_b = 8'h04;
    logic        choice_drv = 1'b0, hold_drv = 1'b0, WB_ACK_O, REF_CHOICE_PIN_I, REF_CHOICE_PIN_O;
    logic        REF_CHOICE_PIN_OE, HOLDOVER_PIN_I, HOLDOVER_PIN_O, HOLDOVER_PIN_OE, ACTIVE_REF, HOLDOVER_ACTIVE, IRQ;
    int          errors = 0, compares = 0;

    ref_monitor_switchover DUT (.CLK, .RST_B, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_WE_I, .WB_SEL_I, .WB_CYC_I,
        .WB_STB_I, .WB_ACK_O, .REF_IN, .REF_CHOICE_PIN_I, .REF_CHOICE_PIN_O, .REF_CHOICE_PIN_OE, .HOLDOVER_PIN_I,
        .HOLDOVER_PIN_O, .HOLDOVER_PIN_OE, .MULTIPURPOSE_STATUS_PINS, .ACTIVE_REF, .HOLDOVER_ACTIVE, .IRQ);
    ref_source_model u_src (.clk(CLK), .run(run), .half_a(half_a), .half_b(half_b), .choice_drv(choice_drv),
        .hold_drv(hold_drv), .choice_o(REF_CHOICE_PIN_O), .choice_oe(REF_CHOICE_PIN_OE), .hold_o(HOLDOVER_PIN_O),
        .hold_oe(HOLDOVER_PIN_OE), .ref_out(REF_IN), .choice_pin(REF_CHOICE_PIN_I), .hold_pin(HOLDOVER_PIN_I));

    always #2.5 CLK = ~CLK;

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk32
    task automatic chk1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic wb(input logic we, input logic [13:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= {18'h0, a};
        WB_DAT_I <= d;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 50);
        chk1("bus ack", 1'b1, WB_ACK_O);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I  <= 1'b0;
    endtask : wb
    task automatic rd(input logic [13:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        chk32(what, exp, q);
    endtask : rd
    task automatic give_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    initial begin
        int r, h, d, n;
        logic [13:0] base;
        logic [7:0] v;
        void'($urandom(32'h6b2c3845));
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        rd(ADDR_AUTO_MODE, {24'h0, CTRL_RESET}, "auto mode reset");
        rd(ADDR_OVERRIDE, {24'h0, CTRL_RESET}, "override reset");
        rd(ADDR_DIV_B, {16'h0, DIV_RESET}, "divider reset");
        rd(ADDR_HIGH_A, HIGH_RESET, "upper limit reset");
        wb(1'b1, 14'h3F00, 32'hFFFFFFFF);
        rd(14'h3F00, BUS_UNMAPPED, "unmapped read");
        wb(1'b1, ADDR_DIV_A, 32'h0);
        rd(ADDR_DIV_A, 32'h1, "zero divider");
        v = 8'($urandom_range(0, 255));
        wb(1'b1, ADDR_OVERRIDE, {24'h0, v});
        rd(ADDR_OVERRIDE, {24'h0, v}, "override readback");
        wb(1'b1, ADDR_OVERRIDE, 32'h0);
        wb(1'b1, ADDR_PIN_ROUTE, 32'h03010301);
        wb(1'b1, ADDR_IRQ_MASK, 32'h3);
        for (r = 0; r < 2; r++) begin
            base = r ? ADDR_DIV_B : ADDR_DIV_A;
            h = $urandom_range(10, 16);
            d = 2 * $urandom_range(0, 2) + 1;
            n = 2 * h * d;
            if (r) half_b <= 8'(h);
            else half_a <= 8'(h);
            wb(1'b1, base, 32'(d));
            wb(1'b1, base + 14'h4, 32'(n));
            wb(1'b1, base + 14'h8, 32'(n + 21));
            wb(1'b1, ADDR_MON_CTRL, 32'(1 << r));
            repeat (3 * n + 10) @(posedge CLK);
            rd(ADDR_STATUS, 32'h0, "status on low edge");
            wb(1'b1, base + 14'h4, 32'(n + 1));
            repeat (3 * n + 10) @(posedge CLK);
            rd(ADDR_STATUS, 32'(1 << r), "status below low");
            rd(ADDR_IRQ_STAT, 32'(1 << r), "irq status set");
            chk32("status pins", r ? 32'hA : 32'h5, {28'h0, MULTIPURPOSE_STATUS_PINS});
            chk1("irq raised", 1'b1, IRQ);
            wb(1'b1, base + 14'h4, 32'(n - 20));
            wb(1'b1, base + 14'h8, 32'(n));
            repeat (3 * n + 10) @(posedge CLK);
            rd(ADDR_STATUS, 32'h0, "status on high edge");
            rd(ADDR_IRQ_STAT, 32'(1 << r), "irq status kept");
            wb(1'b1, ADDR_IRQ_MASK, 32'h0);
            @(posedge CLK);
            chk1("irq masked", 1'b0, IRQ);
            wb(1'b1, ADDR_IRQ_MASK, 32'h3);
            wb(1'b1, ADDR_IRQ_STAT, 32'(1 << r));
            @(posedge CLK);
            chk1("irq cleared", 1'b0, IRQ);
        end
        wb(1'b1, ADDR_MON_CTRL, 32'h0);
        half_a <= 8'h04;
        half_b <= 8'h04;
        choice_drv <= 1'b1;
        repeat (4) @(posedge CLK);
        chk1("manual ref", 1'b1, ACTIVE_REF);
        chk1("choice pin released", 1'b0, REF_CHOICE_PIN_OE);
        choice_drv <= 1'b0;
        repeat (4) @(posedge CLK);
        chk1("manual ref back", 1'b0, ACTIVE_REF);
        run <= 2'b01;
        wb(1'b1, ADDR_OVERRIDE, 32'(1 << EDGE_ALIGN_BIT));
        choice_drv <= 1'b1;
        repeat (20) @(posedge CLK);
        chk1("switch held", 1'b0, ACTIVE_REF);
        run <= 2'b11;
        repeat (12) @(posedge CLK);
        chk1("switch on edge", 1'b1, ACTIVE_REF);
        choice_drv <= 1'b0;
        wb(1'b1, ADDR_OVERRIDE, 32'h0);
        wb(1'b1, ADDR_AUTO_MODE, 32'(1 << AUTO_REF_BIT));
        repeat (4) @(posedge CLK);
        chk1("choice pin driven", 1'b1, REF_CHOICE_PIN_OE);
        chk1("machine choice", 1'b0, REF_CHOICE_PIN_O);
        wb(1'b1, ADDR_SM_CTRL, 32'h1);
        repeat (8) @(posedge CLK);
        chk1("machine moved", 1'b1, REF_CHOICE_PIN_O);
        chk1("auto ref", 1'b1, ACTIVE_REF);
        wb(1'b1, ADDR_OVERRIDE, 32'(1 << REF_OVR_BIT));
        repeat (4) @(posedge CLK);
        chk1("forced ref", 1'b0, ACTIVE_REF);
        chk1("pin shows machine", 1'b1, REF_CHOICE_PIN_O);
        wb(1'b1, ADDR_SM_CTRL, 32'h0);
        wb(1'b1, ADDR_OVERRIDE, 32'h0);
        wb(1'b1, ADDR_AUTO_MODE, 32'h0);
        hold_drv <= 1'b1;
        repeat (4) @(posedge CLK);
        chk1("manual holdover", 1'b1, HOLDOVER_ACTIVE);
        rd(ADDR_STATUS, 32'h20, "holdover status");
        choice_drv <= 1'b1;
        repeat (6) @(posedge CLK);
        chk1("ref frozen", 1'b0, ACTIVE_REF);
        hold_drv <= 1'b0;
        repeat (6) @(posedge CLK);
        chk1("ref after holdover", 1'b1, ACTIVE_REF);
        wb(1'b1, ADDR_AUTO_MODE, 32'(1 << AUTO_HOLD_BIT));
        wb(1'b1, ADDR_OVERRIDE, 32'h3);
        repeat (4) @(posedge CLK);
        chk1("holdover pin driven", 1'b1, HOLDOVER_PIN_OE);
        chk1("forced holdover", 1'b1, HOLDOVER_ACTIVE);
        chk1("holdover pin machine", 1'b0, HOLDOVER_PIN_O);
        wb(1'b1, ADDR_OVERRIDE, 32'(1 << HOLD_OVR_BIT));
        wb(1'b1, ADDR_AUTO_MODE, 32'(1 << AUTO_HOLD_BIT | 1 << HOLD_MODE_BIT));
        @(posedge CLK);
        chk1("holdover mode bit", 1'b1, HOLDOVER_ACTIVE);
        give_verdict();
    end
endmodule : ref_monitor_switchover_test
